/* raex_core.sv */
// Overview of operation
// RULE_01 - Condition 56 true when duty setting strictly exceeds parameter.
// RULE_02 - Condition 57 true when duty setting strictly below parameter.
// RULE_03 - Duty setting is an unsigned eight-bit value, 0 to 255.
// RULE_04 - Condition 58 tests PWM, LED or transistor on/off picked by parameter 0..5.
// RULE_05 - Rule author uses only on/off parameters 0..5.
// RULE_06 - Action rule is three bytes: type, parameter, next index.
// RULE_07 - Chain stops at index 255 or an index beyond table end.
// RULE_08 - Actions run in chain order from the event's starting action.
// RULE_09 - Rule author keeps non-terminating indices pointing at real actions.
// RULE_10 - Outside normal mode actions altering the transistor are suppressed.
// RULE_11 - A suppressed action still lets the chain continue.
// RULE_12 - Type 100 param 0 off, 1 on, 2 toggles the transistor.
// RULE_13 - Param 3 stops PWM, keeps duty, stored transistor drives pin.
// RULE_14 - Param 4 starts PWM at present duty, overriding transistor setting.
// RULE_15 - Param 5 inverts PWM run state, duty unchanged.
// RULE_16 - Params 6 and 7 send variable one or two over UART.
// RULE_17 - Param 8 sends the duty setting over UART.
// RULE_18 - Author switches transistor off before sending; receiver pulls up.
// RULE_19 - Param 9 stops PWM, turns transistor off, enters configuration mode.
// RULE_20 - Config mode held until a start bit, then a time-out exits it.
// RULE_21 - Output drive accepts params 0..9, skipped outside normal mode.
// RULE_22 - Type 101 sends its parameter byte, skipped outside normal mode.
// RULE_23 - Duty 0 is fully off, 255 fully on.
// RULE_24 - UART frame: start, eight data bits LSB first, stop; idle is off.
// RULE_25 - PWM on time is duty over 255 of a fixed period.
module raex_core #(
   parameter int TABLE_DEPTH = 32,
   parameter int CFG_TMO     = raex_pkg::CFG_TMO_CYCLES
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   input  wire logic                chain_start,
   input  wire logic [7:0]          chain_first,
   output logic                     chain_busy,
   output logic [7:0]               rule_addr,
   input  wire raex_pkg::raex_rule_t rule_data,
   input  wire logic [7:0]          var1,
   input  wire logic [7:0]          var2,
   input  wire logic [7:0]          duty_in,
   input  wire logic                duty_load,
   input  wire logic                led_state,
   input  wire logic [7:0]          cond_kind,
   input  wire logic [7:0]          cond_param,
   output logic                     cond_true,
   input  wire logic                sig_pin_in,
   output logic                     xstr_on,
   output logic                     normal_mode,
   output logic [7:0]               duty,
   output logic                     pwm_run,
   output logic                     out_setting
);
   raex_pkg::raex_state_t state;
   logic [7:0]  idx;
   logic [7:0]  tx_shift;
   logic [3:0]  tx_bits;
   logic [15:0] tx_cnt;
   logic        tx_busy;
   logic        tx_line;
   logic        cfg_mode;
   logic        cfg_tmo_run;
   logic [31:0] cfg_cnt;
   logic [7:0]  pwm_cnt;
   logic        pwm_wave;

   wire idx_end    = (chain_first == raex_pkg::IDX_END) || (32'(chain_first) >= TABLE_DEPTH);
   wire next_end   = (rule_data.next == raex_pkg::IDX_END) || (32'(rule_data.next) >= TABLE_DEPTH); // RULE_07
   wire is_drive   = rule_data.kind == raex_pkg::ACT_DRIVE;
   wire is_txb     = rule_data.kind == raex_pkg::ACT_TX_BYTE;
   wire exec_ok    = (state == raex_pkg::RAEX_EXEC) && !cfg_mode; // RULE_10 RULE_21 RULE_22
   wire drv_go     = exec_ok && is_drive;
   wire tx_req     = exec_ok && (is_txb || (is_drive && (rule_data.param == raex_pkg::DRV_TX_VAR1 ||
                     rule_data.param == raex_pkg::DRV_TX_VAR2 || rule_data.param == raex_pkg::DRV_TX_DUTY)));
   wire [7:0] tx_val = is_txb ? rule_data.param :                                            // RULE_22
                       (rule_data.param == raex_pkg::DRV_TX_VAR1) ? var1 :                    // RULE_16
                       (rule_data.param == raex_pkg::DRV_TX_VAR2) ? var2 : duty;              // RULE_17
   wire cfg_go     = drv_go && rule_data.param == raex_pkg::DRV_CONFIG;
   wire tmo_done   = cfg_tmo_run && (cfg_cnt == 32'(CFG_TMO - 1));

   assign normal_mode = !cfg_mode;
   assign chain_busy  = state != raex_pkg::RAEX_IDLE;
   assign rule_addr   = idx;                                                                  // RULE_06

   // Condition evaluation
   wire [5:0] onoff_vec = {out_setting, !out_setting, led_state, !led_state, pwm_run, !pwm_run};
   assign cond_true = (cond_kind == raex_pkg::COND_DUTY_GT) ? (duty > cond_param) :          // RULE_01
                      (cond_kind == raex_pkg::COND_DUTY_LT) ? (duty < cond_param) :          // RULE_02
                      (cond_kind == raex_pkg::COND_ONOFF && cond_param < 8'h06) ?
                      onoff_vec[cond_param[2:0]] : 1'b0;                                      // RULE_04

   // Chain sequencer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= raex_pkg::RAEX_IDLE;
         idx   <= 8'h00;
      end else begin
         unique case (state)
            raex_pkg::RAEX_IDLE: begin
               if (chain_start && !idx_end) begin                                          // RULE_08
                  idx   <= chain_first;
                  state <= raex_pkg::RAEX_FETCH;
               end
            end
            raex_pkg::RAEX_FETCH: state <= raex_pkg::RAEX_EXEC;
            raex_pkg::RAEX_EXEC: begin
               if (tx_req) begin
                  state <= raex_pkg::RAEX_TXW;
               end else if (next_end) begin                                                 // RULE_11
                  state <= raex_pkg::RAEX_IDLE;
               end else begin
                  idx   <= rule_data.next;
                  state <= raex_pkg::RAEX_FETCH;
               end
            end
            raex_pkg::RAEX_TXW: begin
               if (!tx_busy && next_end) begin
                  state <= raex_pkg::RAEX_IDLE;
               end else if (!tx_busy) begin
                  idx   <= rule_data.next;
                  state <= raex_pkg::RAEX_FETCH;
               end
            end
         endcase
      end
   end

   // Output, PWM and duty state
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_setting <= 1'b0;
         pwm_run     <= 1'b0;
         duty        <= raex_pkg::DUTY_RST;
      end else begin
         if (duty_load) begin
            duty <= duty_in;                                                                // RULE_03
         end
         if (drv_go) begin
            unique case (rule_data.param)
               raex_pkg::DRV_OFF:     out_setting <= 1'b0;                                  // RULE_12
               raex_pkg::DRV_ON:      out_setting <= 1'b1;                                  // RULE_12
               raex_pkg::DRV_TOGGLE:  out_setting <= !out_setting;                          // RULE_12
               raex_pkg::DRV_PWM_OFF: pwm_run <= 1'b0;                                      // RULE_13
               raex_pkg::DRV_PWM_ON:  pwm_run <= 1'b1;                                      // RULE_14
               raex_pkg::DRV_PWM_TOG: pwm_run <= !pwm_run;                                  // RULE_15
               raex_pkg::DRV_CONFIG: begin                                                   // RULE_19
                  pwm_run     <= 1'b0;
                  out_setting <= 1'b0;
               end
               default: ;                                                                   // RULE_21
            endcase
         end
      end
   end

   // PWM: period of 255 counts, high while count below duty
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_cnt <= 8'h00;
      end else begin
         pwm_cnt <= (pwm_cnt == raex_pkg::PWM_PERIOD_M1) ? 8'h00 : pwm_cnt + 8'h01;        // RULE_25
      end
   end
   assign pwm_wave = pwm_cnt < duty;                                                         // RULE_23

   // UART transmitter
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_busy  <= 1'b0;
         tx_shift <= 8'h00;
         tx_bits  <= 4'h0;
         tx_cnt   <= 16'h0000;
         tx_line  <= 1'b0;
      end else if (state == raex_pkg::RAEX_EXEC && tx_req) begin
         tx_busy  <= 1'b1;
         tx_shift <= tx_val;
         tx_bits  <= 4'h0;
         tx_cnt   <= 16'h0000;
         tx_line  <= 1'b1;                                                                  // RULE_24
      end else if (tx_busy) begin
         if (tx_cnt == 16'(raex_pkg::BIT_CYCLES - 1)) begin
            tx_cnt  <= 16'h0000;
            tx_bits <= tx_bits + 4'h1;
            if (tx_bits == raex_pkg::UART_BITS - 4'h1) begin
               tx_busy <= 1'b0;
               tx_line <= 1'b0;
            end else if (tx_bits == raex_pkg::UART_BITS - 4'h2) begin
               tx_line <= 1'b0;
            end else begin
               tx_line  <= !tx_shift[0];                                                    // RULE_24
               tx_shift <= {1'b0, tx_shift[7:1]};
            end
         end else begin
            tx_cnt <= tx_cnt + 16'h0001;
         end
      end
   end

   // Configuration mode and time-out
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_mode    <= 1'b0;
         cfg_tmo_run <= 1'b0;
         cfg_cnt     <= 32'h0;
      end else if (cfg_go) begin
         cfg_mode    <= 1'b1;                                                               // RULE_19
         cfg_tmo_run <= 1'b0;
         cfg_cnt     <= 32'h0;
      end else if (cfg_mode) begin
         if (!cfg_tmo_run && !sig_pin_in) begin
            cfg_tmo_run <= 1'b1;                                                            // RULE_20
         end else if (tmo_done) begin
            cfg_mode    <= 1'b0;                                                            // RULE_20
            cfg_tmo_run <= 1'b0;
         end else if (cfg_tmo_run) begin
            cfg_cnt <= cfg_cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         xstr_on <= 1'b0;
      end else begin
         xstr_on <= tx_busy ? tx_line : (pwm_run ? pwm_wave : out_setting);                 // RULE_14
      end
   end

   property p_cfg_suppress;
      @(posedge ref_clk) disable iff (!rst_b)
         (cfg_mode && state == raex_pkg::RAEX_EXEC) |=> $stable(out_setting) && $stable(pwm_run);
   endproperty
   a_cfg_suppress: assert property (p_cfg_suppress) else $error("output changed in config mode"); // RULE_10

   property p_end_stop;
      @(posedge ref_clk) disable iff (!rst_b)
         (state == raex_pkg::RAEX_EXEC && !tx_req && next_end) |=> state == raex_pkg::RAEX_IDLE;
   endproperty
   a_end_stop: assert property (p_end_stop) else $error("chain did not stop"); // RULE_07

   property p_toggle;
      @(posedge ref_clk) disable iff (!rst_b)
         (drv_go && rule_data.param == raex_pkg::DRV_TOGGLE) |=> out_setting != $past(out_setting);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle failed"); // RULE_12

   property p_cfg_enter;
      @(posedge ref_clk) disable iff (!rst_b)
         cfg_go |=> cfg_mode && !pwm_run && !out_setting;
   endproperty
   a_cfg_enter: assert property (p_cfg_enter) else $error("config entry wrong"); // RULE_19

   property p_gt;
      @(posedge ref_clk) disable iff (!rst_b)
         (cond_kind == raex_pkg::COND_DUTY_GT) |-> cond_true == (duty > cond_param);
   endproperty
   a_gt: assert property (p_gt) else $error("duty gt wrong"); // RULE_01

   property p_lt;
      @(posedge ref_clk) disable iff (!rst_b)
         (cond_kind == raex_pkg::COND_DUTY_LT) |-> cond_true == (duty < cond_param);
   endproperty
   a_lt: assert property (p_lt) else $error("duty lt wrong"); // RULE_02

   property p_start_bit;
      @(posedge ref_clk) disable iff (!rst_b)
         (state == raex_pkg::RAEX_EXEC && tx_req) |=> tx_busy ##1 xstr_on;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("no start bit"); // RULE_24

   property p_pwm_on;
      @(posedge ref_clk) disable iff (!rst_b)
         (drv_go && rule_data.param == raex_pkg::DRV_PWM_ON) |=> pwm_run && ($stable(duty) || $past(duty_load));
   endproperty
   a_pwm_on: assert property (p_pwm_on) else $error("pwm start wrong"); // RULE_14

   property p_pwm_off;
      @(posedge ref_clk) disable iff (!rst_b)
         (drv_go && rule_data.param == raex_pkg::DRV_PWM_OFF) |=> !pwm_run && ($stable(duty) || $past(duty_load));
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("pwm stop wrong"); // RULE_13

   property p_onoff_out;
      @(posedge ref_clk) disable iff (!rst_b)
         (cond_kind == raex_pkg::COND_ONOFF && cond_param == 8'h05) |-> cond_true == out_setting;
   endproperty
   a_onoff_out: assert property (p_onoff_out) else $error("output on test wrong"); // RULE_04

   property p_tx_skip;
      @(posedge ref_clk) disable iff (!rst_b)
         (cfg_mode && state == raex_pkg::RAEX_EXEC) |=> state != raex_pkg::RAEX_TXW;
   endproperty
   a_tx_skip: assert property (p_tx_skip) else $error("transmit ran in config mode"); // RULE_22

   property p_idle_off;
      @(posedge ref_clk) disable iff (!rst_b)
         (!tx_busy && !pwm_run && !out_setting) |=> !xstr_on;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("transistor on while idle"); // RULE_24

   property p_pwm_full;
      @(posedge ref_clk) disable iff (!rst_b)
         (pwm_run && !tx_busy && duty == 8'hFF) |=> xstr_on;
   endproperty
   a_pwm_full: assert property (p_pwm_full) else $error("full duty not on"); // RULE_23
endmodule

/* raex_pkg.sv */
package raex_pkg;
   localparam logic [7:0] COND_DUTY_GT  = 8'h38;
   localparam logic [7:0] COND_DUTY_LT  = 8'h39;
   localparam logic [7:0] COND_ONOFF    = 8'h3A;
   localparam logic [7:0] ACT_DRIVE     = 8'h64;
   localparam logic [7:0] ACT_TX_BYTE   = 8'h65;
   localparam logic [7:0] IDX_END       = 8'hFF;
   localparam logic [7:0] DRV_OFF       = 8'h00;
   localparam logic [7:0] DRV_ON        = 8'h01;
   localparam logic [7:0] DRV_TOGGLE    = 8'h02;
   localparam logic [7:0] DRV_PWM_OFF   = 8'h03;
   localparam logic [7:0] DRV_PWM_ON    = 8'h04;
   localparam logic [7:0] DRV_PWM_TOG   = 8'h05;
   localparam logic [7:0] DRV_TX_VAR1   = 8'h06;
   localparam logic [7:0] DRV_TX_VAR2   = 8'h07;
   localparam logic [7:0] DRV_TX_DUTY   = 8'h08;
   localparam logic [7:0] DRV_CONFIG    = 8'h09;
   localparam logic [7:0] DUTY_RST      = 8'h00;
   localparam logic [7:0] PWM_PERIOD_M1 = 8'hFE;
   localparam int         CLK_HZ        = 100000000;
   localparam int         BAUD          = 9600;
   localparam int         BIT_CYCLES    = CLK_HZ / BAUD;
   localparam int         CFG_TMO_MS    = 100;
   localparam int         CFG_TMO_CYCLES = CFG_TMO_MS * (CLK_HZ / 1000);
   localparam logic [3:0] UART_BITS     = 4'hA;

   typedef struct packed {
      logic [7:0] kind;
      logic [7:0] param;
      logic [7:0] next;
   } raex_rule_t;

   typedef enum logic [1:0] {
      RAEX_IDLE  = 2'b00,
      RAEX_FETCH = 2'b01,
      RAEX_EXEC  = 2'b10,
      RAEX_TXW   = 2'b11
   } raex_state_t;
endpackage

/* raex_rule_mem.sv */
module raex_rule_mem (
   input  wire logic                 ref_clk,
   input  wire logic [7:0]           rule_addr,
   output raex_pkg::raex_rule_t      rule_data
);
   timeunit 1ns;
   timeprecision 100ps;
   raex_pkg::raex_rule_t mem [0:31];
   // Three-byte rule: kind, parameter, next index
   always_ff @(posedge ref_clk) begin
      rule_data <= (rule_addr < 8'h20) ? mem[rule_addr[4:0]] : 24'h5A5AA5;
   end
endmodule

/* testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, rst_b, chain_start, duty_load, led_state, sig_pin_in;
   logic [7:0] chain_first, var1, var2, duty_in, cond_kind, cond_param, rule_addr, duty;
   logic chain_busy, cond_true, xstr_on, normal_mode, pwm_run, out_setting;
   raex_pkg::raex_rule_t rule_data;
   int mismatches, samples_checked;
   localparam int BITC = raex_pkg::BIT_CYCLES;

   raex_core #(.TABLE_DEPTH(32), .CFG_TMO(20)) raex_core_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .chain_start(chain_start), .chain_first(chain_first), .chain_busy(chain_busy), .rule_addr(rule_addr),
      .rule_data(rule_data), .var1(var1), .var2(var2), .duty_in(duty_in), .duty_load(duty_load),
      .led_state(led_state), .cond_kind(cond_kind), .cond_param(cond_param), .cond_true(cond_true),
      .sig_pin_in(sig_pin_in), .xstr_on(xstr_on), .normal_mode(normal_mode), .duty(duty),
      .pwm_run(pwm_run), .out_setting(out_setting));
   raex_rule_mem raex_rule_mem_i (.ref_clk(ref_clk), .rule_addr(rule_addr), .rule_data(rule_data));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic put(input int i, input logic [7:0] k, input logic [7:0] p, input logic [7:0] n);
      raex_rule_mem_i.mem[i] = '{k, p, n};
   endtask
   task automatic run_chain(input logic [7:0] first);
      int t;
      chain_first = first;
      chain_start = 1'b1;
      step(1);
      chain_start = 1'b0;
      t = 0;
      while (chain_busy !== 1'b0 && t < 100) begin
         step(1);
         t++;
      end
      step(2);
      check("chain end", {7'h00, chain_busy}, 8'h00);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic t_reset();
      check("normal", {7'h00, normal_mode}, 8'h01);
      check("outs", {4'h0, xstr_on, pwm_run, out_setting, chain_busy}, 8'h00);
      check("duty", duty, raex_pkg::DUTY_RST);
      $display("reset test done");
   endtask
   task automatic t_cond();
      logic e;
      duty_in = 8'h80;
      duty_load = 1'b1;
      step(1);
      duty_load = 1'b0;
      cond_kind = raex_pkg::COND_DUTY_GT;
      cond_param = 8'h7F;
      step(1);
      check("gt", {7'h00, cond_true}, 8'h01);
      cond_param = 8'h80;
      step(1);
      check("gt eq", {7'h00, cond_true}, 8'h00);
      cond_kind = raex_pkg::COND_DUTY_LT;
      cond_param = 8'h81;
      step(1);
      check("lt", {7'h00, cond_true}, 8'h01);
      cond_param = 8'h80;
      step(1);
      check("lt eq", {7'h00, cond_true}, 8'h00);
      cond_kind = raex_pkg::COND_ONOFF;
      for (int l = 0; l < 2; l++) begin
         for (int p = 0; p < 6; p++) begin
            led_state = l[0];
            cond_param = p[7:0];
            e = (p == 2 || p == 3) ? ((p == 3) == l) : (p == 0 || p == 4);
            step(1);
            check("onoff", {7'h00, cond_true}, {7'h00, e});
         end
      end
      led_state = 1'b0;
      $display("condition test done");
   endtask
   task automatic t_chain();
      put(0, raex_pkg::ACT_DRIVE, raex_pkg::DRV_ON, 8'h01);
      put(1, raex_pkg::ACT_DRIVE, raex_pkg::DRV_TOGGLE, 8'h20);
      put(2, raex_pkg::ACT_DRIVE, raex_pkg::DRV_ON, 8'hFF);
      run_chain(8'h00);
      check("order", {6'h00, out_setting, xstr_on}, 8'h00);
      check("last addr", rule_addr, 8'h01);
      run_chain(8'h02);
      check("on", {6'h00, out_setting, xstr_on}, 8'h03);
      cond_param = 8'h05;
      step(1);
      check("onoff out", {7'h00, cond_true}, 8'h01);
      put(3, raex_pkg::ACT_DRIVE, raex_pkg::DRV_OFF, 8'hFF);
      run_chain(8'h03);
      check("off end", {6'h00, out_setting, xstr_on}, 8'h00);
      $display("chain test done");
   endtask
   task automatic t_pwm();
      logic [7:0] d [3] = '{8'h00, 8'h80, 8'hFF};
      int hi;
      put(10, raex_pkg::ACT_DRIVE, raex_pkg::DRV_PWM_ON, 8'hFF);
      put(11, raex_pkg::ACT_DRIVE, raex_pkg::DRV_PWM_TOG, 8'hFF);
      put(12, raex_pkg::ACT_DRIVE, raex_pkg::DRV_PWM_OFF, 8'hFF);
      run_chain(8'd10);
      check("pwm on", {7'h00, pwm_run}, 8'h01);
      cond_param = 8'h01;
      step(1);
      check("onoff pwm", {7'h00, cond_true}, 8'h01);
      for (int i = 0; i < 3; i++) begin
         duty_in = d[i];
         duty_load = 1'b1;
         step(1);
         duty_load = 1'b0;
         step(3);
         hi = 0;
         for (int c = 0; c < 255; c++) begin
            hi += xstr_on;
            step(1);
         end
         check("pwm high", hi[7:0], d[i]);
      end
      run_chain(8'd11);
      check("pwm tog", {6'h00, pwm_run, xstr_on}, 8'h00);
      check("duty kept", duty, 8'hFF);
      run_chain(8'd11);
      check("pwm tog on", {7'h00, pwm_run}, 8'h01);
      run_chain(8'd12);
      check("pwm off", {6'h00, pwm_run, xstr_on}, 8'h00);
      check("duty same", duty, 8'hFF);
      $display("pwm test done");
   endtask
   task automatic t_config();
      put(4, raex_pkg::ACT_DRIVE, raex_pkg::DRV_ON, 8'h05);
      put(5, raex_pkg::ACT_DRIVE, raex_pkg::DRV_PWM_ON, 8'h06);
      put(6, raex_pkg::ACT_DRIVE, raex_pkg::DRV_CONFIG, 8'h07);
      put(7, raex_pkg::ACT_TX_BYTE, 8'h55, 8'h08);
      put(8, raex_pkg::ACT_DRIVE, raex_pkg::DRV_ON, 8'hFF);
      run_chain(8'h04);
      check("cfg", {5'h00, normal_mode, pwm_run, out_setting}, 8'h00);
      step(50);
      check("cfg hold", {6'h00, normal_mode, xstr_on}, 8'h00);
      sig_pin_in = 1'b0;
      step(1);
      sig_pin_in = 1'b1;
      step(10);
      check("tmo run", {7'h00, normal_mode}, 8'h00);
      step(30);
      check("tmo end", {7'h00, normal_mode}, 8'h01);
      $display("config test done");
   endtask
   task automatic t_tx();
      put(9, raex_pkg::ACT_TX_BYTE, 8'hA5, 8'hFF);
      chain_first = 8'h09;
      chain_start = 1'b1;
      step(1);
      chain_start = 1'b0;
      step(2 + BITC / 2);
      check("start bit", {6'h00, chain_busy, xstr_on}, 8'h03);
      step(BITC);
      check("bit0", {7'h00, xstr_on}, 8'h00);
      step(BITC);
      check("bit1", {7'h00, xstr_on}, 8'h01);
      rst_b = 1'b0;
      step(2);
      rst_b = 1'b1;
      check("mid reset", {6'h00, chain_busy, xstr_on}, 8'h00);
      $display("transmit test done");
   endtask
   task automatic t_tx_src();
      logic [7:0] v1 [3] = '{8'h01, 8'h01, 8'h00};
      logic [7:0] dv [3] = '{8'h00, 8'h01, 8'h01};
      logic [7:0] xp [3] = '{8'h00, 8'h01, 8'h00};
      for (int i = 0; i < 3; i++) begin
         put(13 + i, raex_pkg::ACT_DRIVE, 8'(6 + i), 8'hFF);
         var1 = v1[i];
         var2 = 8'h00;
         duty_in = dv[i];
         duty_load = 1'b1;
         step(1);
         duty_load = 1'b0;
         chain_first = 8'(13 + i);
         chain_start = 1'b1;
         step(1);
         chain_start = 1'b0;
         step(2 + BITC + BITC / 2);
         check("tx source bit0", {7'h00, xstr_on}, xp[i]);
         rst_b = 1'b0;
         step(2);
         rst_b = 1'b1;
      end
      $display("transmit source test done");
   endtask

   initial begin
      mismatches = 0;
      samples_checked = 0;
      rst_b = 1'b0;
      {chain_start, duty_load, led_state} = 3'b000;
      sig_pin_in = 1'b1;
      {chain_first, var1, var2, duty_in, cond_kind, cond_param} = 48'h0;
      for (int i = 0; i < 32; i++) put(i, 8'h00, 8'h00, 8'hFF);
      step(4);
      rst_b = 1'b1;
      t_reset();
      t_cond();
      t_chain();
      t_pwm();
      t_config();
      t_tx();
      t_tx_src();
      close_out();
   end

   initial begin
      step(90000);
      mismatches++;
      close_out();
   end
endmodule
